// *** verilog/pmr_pkg.sv ***
// Shared constants for the power monitor result and scaling register group.
package pmr_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] BUS_VOLTAGE_RESULT_ADDR = 8'h02;
    localparam logic [7:0] POWER_RESULT_ADDR = 8'h03;
    localparam logic [7:0] CURRENT_RESULT_ADDR = 8'h04;
    localparam logic [7:0] FULL_SCALE_SCALING_ADDR = 8'h05;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int BUS_CODE_W = 13;
    localparam int BUS_CODE_LOW_BIT = 3;
    localparam int BUS_CODE_TOP_BIT = 15;
    localparam int CONV_READY_BIT = 1;
    localparam int MATH_OVERFLOW_BIT = 0;
    localparam int CURRENT_SIGN_BIT = 15;
    localparam int SCALING_VOID_BIT = 0;
    localparam int SCALING_TOP_BIT = 15;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:1] SCALING_RESET = 15'h0000;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // ************************************************************
    // Bus voltage ranges
    // ************************************************************
    localparam int BUS_STEP_MV = 4;
    localparam logic [12:0] BUS_FS_32V = 13'h1F40;
    localparam logic [12:0] BUS_FS_16V = 13'h0FA0;

    // ************************************************************
    // Arithmetic scaling
    // ************************************************************
    localparam int CURRENT_SHIFT = 12;
    localparam int POWER_DIVISOR = 5000;
    localparam int POWER_WEIGHT = 20;

    // ************************************************************
    // Operating modes
    // ************************************************************
    typedef enum logic [2:0] {
        PMR_MODE_POWER_DOWN = 3'b000,
        PMR_MODE_SHUNT_TRIG = 3'b001,
        PMR_MODE_BUS_TRIG = 3'b010,
        PMR_MODE_BOTH_TRIG = 3'b011,
        PMR_MODE_DISABLE = 3'b100,
        PMR_MODE_SHUNT_CONT = 3'b101,
        PMR_MODE_BUS_CONT = 3'b110,
        PMR_MODE_BOTH_CONT = 3'b111
    } pmr_mode_type;

endpackage : pmr_pkg

// *** verilog/pmr_bus_range.sv ***
// Bus voltage code limiter for the selected full-scale range.
module pmr_bus_range (
    // Raw code and range
    input wire logic [pmr_pkg::BUS_CODE_W-1:0] raw_code_in,
    input wire logic range_32v_in,
    // Limited code
    output logic [pmr_pkg::BUS_CODE_W-1:0] code_out
);
    import pmr_pkg::*;

    logic [BUS_CODE_W-1:0] full_scale;

    // The front end may run past full scale; the register never reports beyond it.
    assign full_scale = range_32v_in ? BUS_FS_32V : BUS_FS_16V;
    assign code_out = (raw_code_in > full_scale) ? full_scale : raw_code_in;

endmodule : pmr_bus_range

// *** verilog/pmr_current_power.sv ***
// Current and power arithmetic from shunt code, scaling value and bus code.
module pmr_current_power (
    // Operands
    input wire logic [15:0] shunt_code_in,
    input wire logic [15:1] scaling_in,
    input wire logic [pmr_pkg::BUS_CODE_W-1:0] bus_code_in,
    // Results
    output logic [15:0] current_out,
    output logic [15:0] power_out,
    output logic overflow_out
);
    import pmr_pkg::*;

    logic signed [32:0] cur_prod;
    logic signed [32:0] cur_full;
    logic [32:0] cur_mag;
    logic [45:0] pwr_full;
    logic cur_ovf;

    // Shunt is signed, scaling unsigned with its void bit forced to zero.
    assign cur_prod = $signed(shunt_code_in) * $signed({2'b00, scaling_in, 1'b0});
    assign cur_full = cur_prod >>> CURRENT_SHIFT;
    assign cur_ovf = (cur_full > 33'sh0_7FFF) || (cur_full < -33'sh0_8000);
    assign cur_mag = cur_full[32] ? 33'(-cur_full) : 33'(cur_full);
    assign pwr_full = (46'(cur_mag) * 46'(bus_code_in)) / 46'(POWER_DIVISOR);

    assign current_out = cur_full[15:0];
    assign power_out = pwr_full[15:0];
    assign overflow_out = cur_ovf || (pwr_full > 46'hFFFF);

endmodule : pmr_current_power

// *** verilog/pmr_result_regs.sv ***
// Result, status and scaling registers of the power monitor.
module pmr_result_regs (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Register port from the serial interface
    input wire logic [pmr_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    // Conversion sequencer
    input wire logic conv_done_in,
    input wire logic [15:0] shunt_code_in,
    input wire logic [pmr_pkg::BUS_CODE_W-1:0] bus_code_in,
    input wire logic range_32v_in,
    // Configuration mode writes
    input wire logic mode_wr_in,
    input wire pmr_pkg::pmr_mode_type mode_in,
    // Status
    output logic conversion_ready_flag_out,
    output logic math_overflow_flag_out
);
    import pmr_pkg::*;

    // ************************************************************
    // Storage
    // ************************************************************
    logic [BUS_CODE_W-1:0] bus_code;
    logic conversion_ready_flag;
    logic math_overflow_flag;
    logic [15:0] power_result;
    logic [15:0] current_result;
    logic [15:1] scaling;

    logic [BUS_CODE_W-1:0] next_bus_code;
    logic [15:0] next_current;
    logic [15:0] next_power;
    logic next_overflow;
    logic power_read;
    logic active_mode_write;
    logic [15:0] next_rdata;

    // ************************************************************
    // Arithmetic
    // ************************************************************
    pmr_bus_range u_bus_range (
        .raw_code_in(bus_code_in),
        .range_32v_in(range_32v_in),
        .code_out(next_bus_code)
    );

    // Power uses the fresh bus code so both results describe one conversion.
    pmr_current_power u_current_power (
        .shunt_code_in(shunt_code_in),
        .scaling_in(scaling),
        .bus_code_in(next_bus_code),
        .current_out(next_current),
        .power_out(next_power),
        .overflow_out(next_overflow)
    );

    // ************************************************************
    // Results
    // ************************************************************
    // Results change only at the end of a conversion, so reads between
    // conversions always see the last complete set.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_code <= '0;
            current_result <= RESULT_RESET;
            power_result <= RESULT_RESET;
            math_overflow_flag <= 1'b0;
        end else if (conv_done_in) begin
            bus_code <= next_bus_code;
            current_result <= next_current;
            power_result <= next_power;
            math_overflow_flag <= next_overflow;
        end
    end

    // ************************************************************
    // Conversion ready flag
    // ************************************************************
    assign power_read = reg_rd_in && (reg_addr_in == POWER_RESULT_ADDR);
    assign active_mode_write = mode_wr_in && (mode_in != PMR_MODE_POWER_DOWN)
        && (mode_in != PMR_MODE_DISABLE);

    // A completion in the same cycle as a clear wins, so no conversion is lost.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            conversion_ready_flag <= 1'b0;
        end else if (conv_done_in) begin
            conversion_ready_flag <= 1'b1;
        end else if (power_read || active_mode_write) begin
            conversion_ready_flag <= 1'b0;
        end
    end

    // ************************************************************
    // Scaling register
    // ************************************************************
    // Result registers have no write path at all.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scaling <= SCALING_RESET;
        end else if (reg_wr_in && (reg_addr_in == FULL_SCALE_SCALING_ADDR)) begin
            scaling <= reg_wdata_in[SCALING_TOP_BIT:1];
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        unique case (reg_addr_in)
            BUS_VOLTAGE_RESULT_ADDR: begin
                next_rdata = {bus_code, 1'b0, conversion_ready_flag, math_overflow_flag};
            end
            POWER_RESULT_ADDR: begin
                next_rdata = power_result;
            end
            CURRENT_RESULT_ADDR: begin
                next_rdata = current_result;
            end
            FULL_SCALE_SCALING_ADDR: begin
                next_rdata = {scaling, 1'b0};
            end
            default: begin
                next_rdata = UNMAPPED_READ;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    assign conversion_ready_flag_out = conversion_ready_flag;
    assign math_overflow_flag_out = math_overflow_flag;

    // ************************************************************
    // Checks
    // ************************************************************
    // A power read that meets a set flag with no completion beside it must clear it.
    sequence s_ready_power_read;
        conversion_ready_flag && power_read && !conv_done_in;
    endsequence

    a_ready_sets: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        conv_done_in |=> conversion_ready_flag)
        else $error("ready flag not set after conversion");

    a_ready_power_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        s_ready_power_read |=> !conversion_ready_flag)
        else $error("ready flag not cleared by power read");

    a_ready_mode_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (active_mode_write && !conv_done_in) |=> !conversion_ready_flag)
        else $error("ready flag not cleared by active mode write");

    a_ready_pd_keep: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (mode_wr_in && !active_mode_write && !power_read && !conv_done_in)
        |=> $stable(conversion_ready_flag))
        else $error("ready flag changed by power-down write");

    a_scaling_void: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (reg_rd_in && reg_addr_in == FULL_SCALE_SCALING_ADDR)
        |=> !reg_rdata_out[SCALING_VOID_BIT])
        else $error("scaling void bit read as one");

    a_scaling_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == FULL_SCALE_SCALING_ADDR)
        |=> scaling == $past(reg_wdata_in[SCALING_TOP_BIT:1]))
        else $error("scaling write not stored");

    a_bus_full_scale: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (conv_done_in && range_32v_in) |=> bus_code <= BUS_FS_32V)
        else $error("bus code above 32 V full scale");

    a_bus_half_scale: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (conv_done_in && !range_32v_in) |=> bus_code <= BUS_FS_16V)
        else $error("bus code above 16 V full scale");

    a_results_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !conv_done_in |=> $stable(power_result) && $stable(current_result)
        && $stable(bus_code) && $stable(math_overflow_flag))
        else $error("results changed without conversion");

    a_power_read_data: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        power_read |=> reg_rdata_out == $past(power_result))
        else $error("power read returned wrong data");

    a_ro_write_ignored: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == CURRENT_RESULT_ADDR && !conv_done_in)
        |=> $stable(current_result))
        else $error("current register took a write");

endmodule : pmr_result_regs

// *** verif/pmr_host_model.sv ***
// Host-side model that reaches the result registers through the register port.
module pmr_host_model (
    // Clock
    input wire logic ref_clk_in,
    // Register port towards the device
    output logic [7:0] reg_addr_out,
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [15:0] reg_wdata_out,
    input wire logic [15:0] reg_rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_out = 8'h00;
        reg_rd_out = 1'b0;
        reg_wr_out = 1'b0;
        reg_wdata_out = 16'h0000;
    end

    task automatic write_word(input logic [7:0] addr, input logic [15:0] data);
        @(negedge ref_clk_in);
        reg_addr_out = addr;
        reg_wdata_out = data;
        reg_wr_out = 1'b1;
        @(negedge ref_clk_in);
        reg_wr_out = 1'b0;
        // Released data is inverted so that a stale word never passes for a fresh one.
        reg_wdata_out = ~data;
    endtask : write_word

    task automatic read_word(input logic [7:0] addr, output logic [15:0] data);
        @(negedge ref_clk_in);
        reg_addr_out = addr;
        reg_rd_out = 1'b1;
        @(negedge ref_clk_in);
        reg_rd_out = 1'b0;
        data = reg_rdata_in;
    endtask : read_word

    // The code is not right-aligned, so the host drops the flags and the empty bit.
    function automatic logic [12:0] bus_code(input logic [15:0] word);
        return word[15:3];
    endfunction : bus_code

    // Power codes weigh twenty current codes.
    function automatic int power_weight(input int current_weight);
        return 20 * current_weight;
    endfunction : power_weight
endmodule : pmr_host_model

// *** verif/tb_power_monitor_result_regs.sv ***
// Self-checking bench for the power monitor result register group.
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value %s expected %h seen %h", name, exp, got); end end
module tb_power_monitor_result_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pmr_pkg::*;

    typedef struct {
        logic [15:0] shunt;
        logic [12:0] bus;
        logic rng;
        logic [15:0] cal, ebus, ecur, epwr;
        logic eovf;
    } pmr_row_type;

    logic ref_clk = 1'b0, sys_rst = 1'b1, rd, wr, conv_done = 1'b0, rng = 1'b0;
    logic mode_wr = 1'b0, rdy, ovf;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, shunt = 16'h0000, w;
    logic [12:0] bus = 13'h0000;
    pmr_mode_type mode = PMR_MODE_POWER_DOWN;
    int failures = 0, num_checks = 0;
    pmr_row_type rows[4];

    always #2 ref_clk = ~ref_clk;

    pmr_host_model pmr_host_model_i (.ref_clk_in(ref_clk), .reg_addr_out(addr),
        .reg_rd_out(rd), .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));

    pmr_result_regs pmr_result_regs_i (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst),
        .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .conv_done_in(conv_done), .shunt_code_in(shunt),
        .bus_code_in(bus), .range_32v_in(rng), .mode_wr_in(mode_wr), .mode_in(mode),
        .conversion_ready_flag_out(rdy), .math_overflow_flag_out(ovf));

    task automatic convert(input pmr_row_type r);
        @(negedge ref_clk);
        shunt = r.shunt;
        bus = r.bus;
        rng = r.rng;
        conv_done = 1'b1;
        @(negedge ref_clk);
        conv_done = 1'b0;
    endtask : convert

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        rows[0] = '{16'h07D0, 13'h0BB3, 1'b0, 16'h5001, 16'h5D9A, 16'h2710, 16'h1766, 1'b0};
        rows[1] = '{16'hF830, 13'h1FFF, 1'b1, 16'h5000, 16'hFA02, 16'hD8F0, 16'h3E80, 1'b0};
        rows[2] = '{16'hFFFF, 13'h1F40, 1'b0, 16'h0002, 16'h7D02, 16'hFFFF, 16'h0000, 1'b0};
        rows[3] = '{16'h7FFF, 13'h0000, 1'b1, 16'hFFFE, 16'h0003, 16'hFFE0, 16'h0000, 1'b1};
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        for (int a = 2; a < 6; a++) begin
            pmr_host_model_i.read_word(8'(a), w);
            `CHK("reset word", 16'h0000, w)
        end
        `CHK("reset flags", 2'b00, {rdy, ovf})
        $display("reset test done");
        foreach (rows[i]) begin
            pmr_host_model_i.write_word(FULL_SCALE_SCALING_ADDR, rows[i].cal);
            convert(rows[i]);
            pmr_host_model_i.read_word(FULL_SCALE_SCALING_ADDR, w);
            `CHK("scaling", rows[i].cal & 16'hFFFE, w)
            `CHK("ready set", 1'b1, rdy)
            pmr_host_model_i.read_word(BUS_VOLTAGE_RESULT_ADDR, w);
            `CHK("bus word", rows[i].ebus, w)
            `CHK("bus code", rows[i].ebus[15:3], pmr_host_model_i.bus_code(w))
            pmr_host_model_i.read_word(POWER_RESULT_ADDR, w);
            `CHK("power", rows[i].epwr, w)
            `CHK("ready cleared", 1'b0, rdy)
            pmr_host_model_i.read_word(CURRENT_RESULT_ADDR, w);
            `CHK("current", rows[i].ecur, w)
            `CHK("overflow", rows[i].eovf, ovf)
            $display("row %0d done", i);
        end
        pmr_host_model_i.write_word(FULL_SCALE_SCALING_ADDR, rows[0].cal);
        convert(rows[0]);
        for (int a = 2; a < 5; a++) begin
            pmr_host_model_i.write_word(8'(a), 16'h1234);
        end
        `CHK("ready kept", 1'b1, rdy)
        pmr_host_model_i.read_word(CURRENT_RESULT_ADDR, w);
        `CHK("current kept", rows[0].ecur, w)
        pmr_host_model_i.read_word(BUS_VOLTAGE_RESULT_ADDR, w);
        `CHK("bus kept", rows[0].ebus, w)
        pmr_host_model_i.read_word(POWER_RESULT_ADDR, w);
        `CHK("power kept", rows[0].epwr, w)
        `CHK("power weight", POWER_WEIGHT, pmr_host_model_i.power_weight(1))
        pmr_host_model_i.read_word(8'h06, w);
        `CHK("unmapped", 16'h0000, w)
        $display("write protect test done");
        for (int m = 0; m < 8; m++) begin
            convert(rows[1]);
            @(negedge ref_clk);
            mode = pmr_mode_type'(m);
            mode_wr = 1'b1;
            @(negedge ref_clk);
            mode_wr = 1'b0;
            `CHK("ready after mode", (m == 0 || m == 4) ? 1'b1 : 1'b0, rdy)
        end
        pmr_host_model_i.read_word(POWER_RESULT_ADDR, w);
        `CHK("power after mode", rows[1].epwr, w)
        $display("mode test done");
        convert(rows[1]);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        `CHK("flags after reset", 2'b00, {rdy, ovf})
        pmr_host_model_i.read_word(CURRENT_RESULT_ADDR, w);
        `CHK("current after reset", 16'h0000, w)
        pmr_host_model_i.read_word(FULL_SCALE_SCALING_ADDR, w);
        `CHK("scaling after reset", 16'h0000, w)
        $display("second reset test done");
        results();
    end
endmodule : tb_power_monitor_result_regs
